// ==== logic/ivm_pkg.sv ====
// Purpose: Constants for the interrupt vector map and priority block.
// Assumes: Vector slot k sits at byte address 0xFF80 + 2*k.
// Notes:   Byte offsets are Wishbone byte addresses of 32-bit words.
`default_nettype none

package ivm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Vector slots
    localparam int unsigned SLOT_N      = 64;
    localparam logic [7:0]  VEC_PAGE    = 8'hff;   // High byte of a vector
    localparam logic [8:0]  VEC_TOP     = 9'h1ff;  // Address bits 15..7
    localparam int unsigned SLOT_RESET  = 63;      // 0xFFFE
    localparam int unsigned SLOT_CLKMON = 62;      // 0xFFFC
    localparam int unsigned SLOT_WDOG   = 61;      // 0xFFFA
    localparam int unsigned SLOT_TRAP   = 60;      // 0xFFF8
    localparam int unsigned SLOT_SWI    = 59;      // 0xFFF6
    localparam int unsigned SLOT_XREQ   = 58;      // 0xFFF4
    localparam int unsigned SLOT_TCH0   = 55;      // 0xFFEE
    localparam int unsigned SLOT_TCH7   = 48;      // 0xFFE0
    localparam int unsigned SLOT_TOVF   = 47;      // 0xFFDE
    localparam int unsigned SLOT_PAOVF  = 46;      // 0xFFDC
    localparam int unsigned SLOT_PAEDGE = 45;      // 0xFFDA
    localparam int unsigned SLOT_MODUF  = 37;      // 0xFFCA
    localparam int unsigned SLOT_PBOVF  = 36;      // 0xFFC8
    localparam int unsigned SLOT_FIRST  = 6;       // 0xFF8C, lower are spare

    ////////////////////////////////////////////////////////////////////////
    // Priority elevation values
    localparam logic [7:0]  ELEV_LOW    = 8'h8c;
    localparam logic [7:0]  ELEV_HIGH   = 8'hf2;
    localparam logic [7:0]  ELEV_RST    = 8'hf2;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [11:0] REG_CTRL    = 12'h000;
    localparam logic [11:0] REG_ELEV    = 12'h004;
    localparam logic [11:0] REG_LEN_LO  = 12'h008;
    localparam logic [11:0] REG_LEN_HI  = 12'h00c;
    localparam logic [11:0] REG_PND_LO  = 12'h010;
    localparam logic [11:0] REG_PND_HI  = 12'h014;
    localparam logic [11:0] REG_STS     = 12'h018;
    localparam logic [11:0] REG_CLR     = 12'h01c;
    localparam logic [11:0] REG_IEN     = 12'h020;
    localparam logic [11:0] REG_SERV    = 12'h024;
    localparam logic [3:0]  TABLE_PAGE  = 4'h1;    // 0x100 + 4*slot

    ////////////////////////////////////////////////////////////////////////
    // Fields and reset values
    localparam int unsigned CTRL_CME    = 0;
    localparam int unsigned CTRL_SELF_CLOCK_MODE_ENABLE   = 1;
    localparam int unsigned CTRL_WDOG   = 2;
    localparam int unsigned STS_SERVED  = 0;
    localparam int unsigned STS_SPUR    = 1;
    localparam int unsigned STS_ELEVBAD = 2;
    localparam logic [2:0]  CTRL_RST    = 3'h0;
    localparam logic [2:0]  IEN_RST     = 3'h0;
    localparam logic [63:0] LEN_RST     = 64'h0;

endpackage

`default_nettype wire

// ==== logic/ivm_top.sv ====
// Purpose: Interrupt vector map, gating and priority select for a CPU.
// Assumes: Source requests, CPU masks and ack are on REF_CLK_I.
// Notes:   Handler table, enables and elevation are set over Wishbone.
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`default_nettype none

// Function
// [RULE1] Clock-monitor vector 0xFFFC, ignores CPU masks, gated by monitor enables.
// [RULE2] Timer channels 0..7 at 0xFFEE down to 0xFFE0, I mask and enable.
// [RULE3] Timer overflow vector 0xFFDE, gated by I mask and its enable.
// [RULE4] Pulse accumulator A overflow vector 0xFFDC, I mask and enable.
// [RULE5] Pulse accumulator edge vector 0xFFDA, I mask and enable.
// [RULE6] Modulus counter underflow vector 0xFFCA, I mask and enable.
// [RULE7] Pulse accumulator B overflow vector 0xFFC8, I mask and enable.
// [RULE8] Elevation register takes the low byte of an I-maskable vector only.
// [RULE9] Vector is two bytes, high byte first; reset at 0xFFFE never masked.
// [RULE10] Highest pending vector wins; elevated I source beats other I sources.
// [RULE11] Spare slots 0xFF80 to 0xFF8B are never produced.
module ivm_top
(
    // Clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        NRST_I,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [11:0] WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // Peripheral request levels, one per vector slot
    input  wire logic [63:0] SRC_REQ_I,
    // CPU side
    input  wire logic        CPU_I_MASK_I,
    input  wire logic        CPU_X_MASK_I,
    input  wire logic        CPU_ACK_I,
    input  wire logic [15:0] VEC_ADDR_I,
    output logic             CPU_REQ_O,
    output logic      [15:0] CPU_VECTOR_O,
    output logic      [7:0]  VEC_DATA_O,
    // Block interrupt
    output logic             IRQ_O
);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [2:0]        ctrl;
        logic [7:0]        elev;
        logic [63:0]       local_en;
        logic [2:0]        sts;
        logic [2:0]        ien;
        logic              ack;
        logic [31:0]       rdata;
        logic              req;
        logic [15:0]       vec;
        logic [7:0]        vdata;
        logic              irq;
        logic [63:0][15:0] table_h;
    } ivm_state_s;

    ivm_state_s q;
    ivm_state_s d;
    logic [63:0] gate;
    logic [63:0] live;
    logic [5:0]  sel_slot;
    logic        elev_hit;
    logic        nmi_hit;

    // Byte-lane merge for a write under WB_SEL_I
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Only even values inside the I-maskable range may be elevated
    function automatic logic elev_ok(input logic [7:0] v);
        return !v[0] && v >= ivm_pkg::ELEV_LOW && v <= ivm_pkg::ELEV_HIGH;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Source gating; spare low slots stay zero so they never win
    always_comb
    begin
        gate = '0;
        for (int k = ivm_pkg::SLOT_FIRST; k < ivm_pkg::SLOT_XREQ; k++)
        begin
            gate[k] = !CPU_I_MASK_I && q.local_en[k]; // [RULE2] [RULE3]
        end
        gate[ivm_pkg::SLOT_XREQ]   = !CPU_X_MASK_I;
        gate[ivm_pkg::SLOT_SWI]    = 1'b1;
        gate[ivm_pkg::SLOT_TRAP]   = 1'b1;
        gate[ivm_pkg::SLOT_WDOG]   = q.ctrl[ivm_pkg::CTRL_WDOG];
        gate[ivm_pkg::SLOT_CLKMON] = q.ctrl[ivm_pkg::CTRL_CME]
                                   | q.ctrl[ivm_pkg::CTRL_SELF_CLOCK_MODE_ENABLE]; // [RULE1]
        gate[ivm_pkg::SLOT_RESET]  = 1'b1; // [RULE9]
        live = SRC_REQ_I & gate; // [RULE11]
    end

    ////////////////////////////////////////////////////////////////////////
    // Priority select. An ascending scan keeps the highest hit. Sources
    // outside the I mask always beat an elevated one.
    always_comb
    begin
        logic [5:0] top_nmi;
        logic [5:0] top_i;
        top_nmi = '0;
        top_i   = '0;
        nmi_hit = 1'b0;
        for (int k = 0; k < ivm_pkg::SLOT_N; k++)
        begin
            if (live[k] && k >= ivm_pkg::SLOT_XREQ)
            begin
                top_nmi = 6'(k);
                nmi_hit = 1'b1;
            end
            else if (live[k])
            begin
                top_i = 6'(k);
            end
        end
        elev_hit = live[q.elev[6:1]];
        if (nmi_hit)
        begin
            sel_slot = top_nmi; // [RULE10]
        end
        else if (elev_hit)
        begin
            sel_slot = q.elev[6:1]; // [RULE10]
        end
        else
        begin
            sel_slot = top_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: bus slave, status, CPU outputs and vector byte fetch
    always_comb
    begin
        logic        acc;
        logic [11:0] wadr;
        logic [5:0]  tslot;
        logic [2:0]  ev;
        logic [2:0]  clr;
        logic [31:0] m;
        d     = q;
        acc   = WB_CYC_I && WB_STB_I && !q.ack;
        wadr  = {WB_ADR_I[11:2], 2'h0};
        tslot = WB_ADR_I[7:2];
        ev    = '0;
        clr   = '0;
        m     = '0;
        d.ack = acc;
        if (acc && WB_WE_I)
        begin
            if (WB_ADR_I[11:8] == ivm_pkg::TABLE_PAGE)
            begin
                m = lane_merge({16'h0, q.table_h[tslot]}, WB_DAT_I, WB_SEL_I);
                d.table_h[tslot] = m[15:0];
            end
            else
            begin
                case (wadr)
                    ivm_pkg::REG_CTRL:
                    begin
                        m = lane_merge({29'h0, q.ctrl}, WB_DAT_I, WB_SEL_I);
                        d.ctrl = m[2:0];
                    end
                    ivm_pkg::REG_ELEV:
                    begin
                        if (WB_SEL_I[0] && elev_ok(WB_DAT_I[7:0]))
                        begin
                            d.elev = WB_DAT_I[7:0]; // [RULE8]
                        end
                        else if (WB_SEL_I[0])
                        begin
                            ev[ivm_pkg::STS_ELEVBAD] = 1'b1; // [RULE8]
                        end
                    end
                    ivm_pkg::REG_LEN_LO:
                    begin
                        d.local_en[31:0] = lane_merge(q.local_en[31:0],
                                                      WB_DAT_I, WB_SEL_I);
                    end
                    ivm_pkg::REG_LEN_HI:
                    begin
                        d.local_en[63:32] = lane_merge(q.local_en[63:32],
                                                       WB_DAT_I, WB_SEL_I);
                    end
                    ivm_pkg::REG_CLR:
                    begin
                        clr = WB_SEL_I[0] ? WB_DAT_I[2:0] : 3'h0;
                    end
                    ivm_pkg::REG_IEN:
                    begin
                        m = lane_merge({29'h0, q.ien}, WB_DAT_I, WB_SEL_I);
                        d.ien = m[2:0];
                    end
                    default:
                    begin
                        d.rdata = '0; // Unmapped or read-only: write dropped
                    end
                endcase
            end
        end
        // Read data; unmapped words read as zero
        if (acc && !WB_WE_I)
        begin
            if (WB_ADR_I[11:8] == ivm_pkg::TABLE_PAGE)
            begin
                d.rdata = {16'h0, q.table_h[tslot]};
            end
            else
            begin
                case (wadr)
                    ivm_pkg::REG_CTRL:   d.rdata = {29'h0, q.ctrl};
                    ivm_pkg::REG_ELEV:   d.rdata = {24'h0, q.elev};
                    ivm_pkg::REG_LEN_LO: d.rdata = q.local_en[31:0];
                    ivm_pkg::REG_LEN_HI: d.rdata = q.local_en[63:32];
                    ivm_pkg::REG_PND_LO: d.rdata = live[31:0];
                    ivm_pkg::REG_PND_HI: d.rdata = live[63:32];
                    ivm_pkg::REG_STS:    d.rdata = {29'h0, q.sts};
                    ivm_pkg::REG_IEN:    d.rdata = {29'h0, q.ien};
                    ivm_pkg::REG_SERV:   d.rdata = {15'h0, q.req, q.vec};
                    default:             d.rdata = '0;
                endcase
            end
        end
        // CPU acknowledge events; a set in the clear cycle survives
        ev[ivm_pkg::STS_SERVED] = CPU_ACK_I && q.req;
        ev[ivm_pkg::STS_SPUR]   = CPU_ACK_I && !q.req;
        d.sts = (q.sts & ~clr) | ev;
        d.irq = |(d.sts & d.ien);
        // Vector address of the winner: page, one, slot, even byte
        d.req = |live;
        d.vec = {ivm_pkg::VEC_PAGE, 1'b1, sel_slot, 1'b0}; // [RULE10]
        // Even byte of a slot returns the handler's high byte
        if (VEC_ADDR_I[15:7] == ivm_pkg::VEC_TOP)
        begin
            d.vdata = VEC_ADDR_I[0] ? q.table_h[VEC_ADDR_I[6:1]][7:0]
                                    : q.table_h[VEC_ADDR_I[6:1]][15:8]; // [RULE9]
        end
        else
        begin
            d.vdata = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register the state
    always_ff @(posedge REF_CLK_I)
    begin
        if (!NRST_I)
        begin
            q          <= '0;
            q.ctrl     <= ivm_pkg::CTRL_RST;
            q.elev     <= ivm_pkg::ELEV_RST;
            q.ien      <= ivm_pkg::IEN_RST;
            q.local_en <= ivm_pkg::LEN_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops
    assign WB_ACK_O     = q.ack;
    assign WB_DAT_O     = q.rdata;
    assign CPU_REQ_O    = q.req;
    assign CPU_VECTOR_O = q.vec;
    assign VEC_DATA_O   = q.vdata;
    assign IRQ_O        = q.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);

    logic [7:0] fetch_hi;
    logic       cm_en;
    assign fetch_hi = q.table_h[VEC_ADDR_I[6:1]][15:8];
    assign cm_en    = q.ctrl[ivm_pkg::CTRL_CME] | q.ctrl[ivm_pkg::CTRL_SELF_CLOCK_MODE_ENABLE];

    sequence s_bad_elev_wr;
        WB_CYC_I && WB_STB_I && WB_WE_I && !q.ack && WB_SEL_I[0]
        && WB_ADR_I[11:2] == ivm_pkg::REG_ELEV[11:2] && !elev_ok(WB_DAT_I[7:0]);
    endsequence
    sequence s_elev_pending;
        elev_hit && !nmi_hit;
    endsequence

    AST_CLKMON_HIT: assert property ( // [RULE1]
        SRC_REQ_I[62] && cm_en && !SRC_REQ_I[63] |=> CPU_VECTOR_O == 16'hfffc)
        else $error("clock monitor vector not selected");
    AST_CLKMON_OFF: assert property ( // [RULE1]
        !cm_en |=> !(CPU_REQ_O && CPU_VECTOR_O == 16'hfffc))
        else $error("clock monitor vector while disabled");
    AST_TIMER_MASKED: assert property ( // [RULE2]
        CPU_I_MASK_I |=> !(CPU_VECTOR_O <= 16'hffee
                         && CPU_VECTOR_O >= 16'hffe0 && CPU_REQ_O))
        else $error("timer channel served under I mask");
    AST_TOVF_GATE: assert property ( // [RULE3]
        CPU_REQ_O && CPU_VECTOR_O == 16'hffde
        |-> $past(SRC_REQ_I[47] && q.local_en[47] && !CPU_I_MASK_I))
        else $error("timer overflow vector without cause");
    AST_PAOVF_GATE: assert property ( // [RULE4]
        CPU_REQ_O && CPU_VECTOR_O == 16'hffdc
        |-> $past(SRC_REQ_I[46] && q.local_en[46] && !CPU_I_MASK_I))
        else $error("accumulator A overflow vector without cause");
    AST_PAEDGE_GATE: assert property ( // [RULE5]
        CPU_REQ_O && CPU_VECTOR_O == 16'hffda
        |-> $past(SRC_REQ_I[45] && q.local_en[45] && !CPU_I_MASK_I))
        else $error("accumulator edge vector without cause");
    AST_MODUF_GATE: assert property ( // [RULE6]
        CPU_REQ_O && CPU_VECTOR_O == 16'hffca
        |-> $past(SRC_REQ_I[37] && q.local_en[37] && !CPU_I_MASK_I))
        else $error("modulus underflow vector without cause");
    AST_PBOVF_GATE: assert property ( // [RULE7]
        CPU_REQ_O && CPU_VECTOR_O == 16'hffc8
        |-> $past(SRC_REQ_I[36] && q.local_en[36] && !CPU_I_MASK_I))
        else $error("accumulator B overflow vector without cause");
    AST_ELEV_REJECT: assert property ( // [RULE8]
        s_bad_elev_wr |=> $stable(q.elev) ##1 q.sts[ivm_pkg::STS_ELEVBAD])
        else $error("bad elevation value accepted");
    AST_RESET_VEC: assert property ( // [RULE9]
        SRC_REQ_I[63] |=> CPU_REQ_O && CPU_VECTOR_O == 16'hfffe)
        else $error("reset vector not selected");
    AST_FETCH_HI: assert property ( // [RULE9]
        VEC_ADDR_I[15:7] == 9'h1ff && !VEC_ADDR_I[0]
        |=> VEC_DATA_O == $past(fetch_hi))
        else $error("even vector byte is not the high byte");
    AST_ELEV_WINS: assert property ( // [RULE10]
        s_elev_pending |=> CPU_VECTOR_O == {8'hff, $past(q.elev)})
        else $error("elevated source did not win");
    AST_NO_SPARE: assert property ( // [RULE11]
        CPU_REQ_O |-> CPU_VECTOR_O >= 16'hff8c)
        else $error("spare vector slot produced");

endmodule

`default_nettype wire

// ==== test/ivm_cpu_model.sv ====
// Purpose: CPU core and peripheral sources facing the vector block.
// Assumes: One vector fetch per fetch_i pulse, after stall_i cycles.
// Notes:   Handler bytes come back one cycle after their address.
`default_nettype none

module ivm_cpu_model
(
    // Clock
    input  wire logic        clk_i,
    // Bench commands
    input  wire logic [63:0] src_i,
    input  wire logic        i_mask_i,
    input  wire logic        x_mask_i,
    input  wire logic        fetch_i,
    input  wire logic [3:0]  stall_i,
    // Block side
    input  wire logic        cpu_req_i,
    input  wire logic [15:0] cpu_vector_i,
    input  wire logic [7:0]  vec_data_i,
    output logic      [63:0] src_req_o,
    output logic             i_mask_o,
    output logic             x_mask_o,
    output logic             cpu_ack_o,
    output logic      [15:0] vec_addr_o,
    // Fetch result {taken, vector, handler}
    output logic             done_o,
    output logic      [32:0] res_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic        taken;
    logic [15:0] vec;
    logic [7:0]  hi;

    // Source levels and mask bits follow the bench with no delay
    assign src_req_o = src_i;
    assign i_mask_o  = i_mask_i;
    assign x_mask_o  = x_mask_i;

    // Ack only a live request; a stall models a slow instruction end
    initial
    begin
        cpu_ack_o  = 1'b0;
        vec_addr_o = 16'h0000;
        done_o     = 1'b0;
        res_o      = 33'h0;
        forever
        begin
            @(posedge clk_i);
            done_o <= 1'b0;
            if (fetch_i)
            begin
                repeat (stall_i) @(posedge clk_i);
                taken = cpu_req_i;
                vec   = cpu_vector_i;
                res_o <= 33'h0;
                if (taken)
                begin
                    cpu_ack_o  <= 1'b1;
                    vec_addr_o <= vec;
                    @(posedge clk_i);
                    cpu_ack_o  <= 1'b0;
                    vec_addr_o <= vec | 16'h0001;
                    @(posedge clk_i);
                    hi = vec_data_i;
                    vec_addr_o <= 16'h0000;
                    @(posedge clk_i);
                    res_o <= {1'b1, vec, hi, vec_data_i};
                end
                done_o <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ==== test/interrupt_vector_map_bench.sv ====
// Purpose: Self-checking bench for the vector map and priority block.
// Assumes: Wishbone answers within 20 cycles; sources are levels.
// Notes:   Drivers queue expectations, monitors pop them on results.
`default_nettype none

module interrupt_vector_map_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, nrst, cyc, stb, we, fetch, imask, xmask;
    logic [11:0] adr;
    logic [31:0] wdat;
    logic [63:0] src;
    logic [3:0]  stall;
    wire  [31:0] rdat;
    wire  [63:0] src_req;
    wire  [15:0] vaddr, cvec;
    wire  [7:0]  vdata;
    wire  [32:0] res;
    wire         ack, im, xm, cack, creq, irq, done;
    int          err_total, comparisons;
    logic [31:0] rd_q[$];
    logic [32:0] cpu_q[$];
    logic [2:0]  ctrl_s;
    logic [63:0] len_s;
    logic [7:0]  elev_s;
    int          slots[15] = '{55, 54, 53, 52, 51, 50, 49, 48,
                               47, 46, 45, 37, 36, 57, 6};
    logic [7:0]  bad[4] = '{8'hf4, 8'hc9, 8'h8a, 8'hfe};
    logic [63:0] s;

    ivm_top ivm_top_i (.REF_CLK_I(clk), .NRST_I(nrst), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .SRC_REQ_I(src_req), .CPU_I_MASK_I(im),
        .CPU_X_MASK_I(xm), .CPU_ACK_I(cack), .VEC_ADDR_I(vaddr),
        .CPU_REQ_O(creq), .CPU_VECTOR_O(cvec), .VEC_DATA_O(vdata),
        .IRQ_O(irq));

    ivm_cpu_model ivm_cpu_model_i (.clk_i(clk), .src_i(src),
        .i_mask_i(imask), .x_mask_i(xmask), .fetch_i(fetch),
        .stall_i(stall), .cpu_req_i(creq), .cpu_vector_i(cvec),
        .vec_data_i(vdata), .src_req_o(src_req), .i_mask_o(im),
        .x_mask_o(xm), .cpu_ack_o(cack), .vec_addr_o(vaddr),
        .done_o(done), .res_o(res));

    ////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and verdict
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        report_and_stop();
    end

    task automatic report_and_stop();
        if (err_total == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [32:0] e,
                       input logic [32:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Bus master; the request holds until the edge that sees ack
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        {cyc, stb, we} <= 3'b000;
        if (n >= 20)
            cmp("wb_ack", 33'h1, 33'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask

    // Handler word chosen so that each byte differs between slots
    function automatic logic [15:0] hnd(input int k);
        return 16'(k * 16'h0a53) ^ 16'h3c00;
    endfunction

    // Winner from the gating and priority that the rules give
    function automatic logic [32:0] expect_cpu(input logic [63:0] r,
                                               input logic i, x);
        logic [63:0] g;
        int          w;
        int          ev;
        g = r & {1'b1, ctrl_s[0] | ctrl_s[1], ctrl_s[2], 2'b11, ~x,
                 {52{~i}} & len_s[57:6], 6'h00};
        w = -1;
        ev = int'(elev_s) / 2 - 64;
        for (int k = 63; k >= 58; k--)
            if (g[k] && w < 0) w = k;
        if (w < 0 && g[ev]) w = ev;
        for (int k = 57; k >= 6; k--)
            if (g[k] && w < 0) w = k;
        if (w < 0) return 33'h0;
        return {1'b1, 16'hff80 + 16'(2 * w), hnd(w)};
    endfunction

    // Set levels, let them settle, then ask the CPU model to fetch
    task automatic cpu_try(input logic [63:0] r, input logic i, x);
        int n;
        @(posedge clk);
        {src, imask, xmask} <= {r, i, x};
        repeat (3) @(posedge clk);
        cpu_q.push_back(expect_cpu(r, i, x));
        fetch <= 1'b1;
        @(posedge clk);
        fetch <= 1'b0;
        n = 0;
        while (cpu_q.size() > 0 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 40)
            cmp("cpu_done", 33'h1, 33'h0);
    endtask

    task automatic chk_irq(input logic e);
        repeat (3) @(posedge clk);
        cmp("irq", {32'h0, e}, {32'h0, irq});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Monitors take the oldest note whenever a result shows
    always @(posedge clk)
        if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0)
            cmp("wb_read", {1'b0, rd_q.pop_front()}, {1'b0, rdat});

    always @(posedge clk)
        if (done === 1'b1 && cpu_q.size() > 0)
            cmp("cpu_fetch", cpu_q.pop_front(), res);

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {nrst, cyc, stb, we, fetch, imask, xmask} = 7'h00;
        {adr, wdat, src, stall} = '0;
        {ctrl_s, len_s, elev_s} = {3'h0, 64'h0, 8'hf2};
        void'($urandom(7446));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd(ivm_pkg::REG_CTRL, 32'h0);
        rd(ivm_pkg::REG_ELEV, 32'h0000_00f2);
        rd(ivm_pkg::REG_LEN_HI, 32'h0);
        rd(12'h0f0, 32'h0);
        for (int k = 6; k < 64; k++)
            wb(1'b1, {ivm_pkg::TABLE_PAGE, 8'(4 * k)}, {16'h0, hnd(k)});
        cpu_try(64'h1 << 55, 1'b0, 1'b1);
        wb(1'b1, ivm_pkg::REG_LEN_LO, 32'hffff_ffff);
        wb(1'b1, ivm_pkg::REG_LEN_HI, 32'hffff_7fff);
        len_s = 64'hffff_7fff_ffff_ffff;
        cpu_try(64'h1 << 47, 1'b0, 1'b1);
        wb(1'b1, ivm_pkg::REG_LEN_HI, 32'hffff_ffff);
        len_s = '1;
        foreach (slots[j])
        begin
            cpu_try(64'h1 << slots[j], 1'b0, 1'b1);
            cpu_try(64'h1 << slots[j], 1'b1, 1'b0);
        end
        for (int c = 0; c < 5; c++)
        begin
            wb(1'b1, ivm_pkg::REG_CTRL, 32'(c));
            ctrl_s = 3'(c);
            rd(ivm_pkg::REG_CTRL, 32'(c));
            cpu_try(64'h1 << 62, 1'b1, 1'b1);
        end
        cpu_try(64'hc000_0000_0000_0000, 1'b1, 1'b1);
        cpu_try(64'h3f, 1'b0, 1'b0);
        s = (64'h1 << 55) | (64'h1 << 45) | (64'h1 << 36) | 64'h1;
        cpu_try(s, 1'b0, 1'b1);
        wb(1'b1, ivm_pkg::REG_ELEV, 32'h0000_00c8);
        elev_s = 8'hc8;
        cpu_try(s, 1'b0, 1'b1);
        cpu_try(s | (64'h1 << 58), 1'b0, 1'b0);
        foreach (bad[j])
        begin
            wb(1'b1, ivm_pkg::REG_ELEV, {24'h0, bad[j]});
            rd(ivm_pkg::REG_ELEV, 32'h0000_00c8);
        end
        rd(ivm_pkg::REG_STS, 32'h5);
        wb(1'b1, ivm_pkg::REG_IEN, 32'h0);
        chk_irq(1'b0);
        wb(1'b1, ivm_pkg::REG_IEN, 32'h4);
        chk_irq(1'b1);
        wb(1'b1, ivm_pkg::REG_CLR, 32'h4);
        chk_irq(1'b0);
        rd(ivm_pkg::REG_STS, 32'h1);
        wb(1'b1, ivm_pkg::REG_ELEV, 32'h0000_00c0);
        elev_s = 8'hc0;
        wb(1'b1, ivm_pkg::REG_LEN_LO, $urandom);
        len_s[31:0] = 32'h0;
        for (int t = 0; t < 40; t++)
        begin
            s = {$urandom, $urandom} & {$urandom, $urandom};
            if ($urandom % 4 != 0) s[63:59] = 5'h00;
            if (t == 0) len_s[31:0] = '1;
            stall <= 4'($urandom % 4);
            cpu_try(s, 1'($urandom), 1'($urandom));
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
